// >>> chan_seq_pkg.sv
package chan_seq_pkg;

	// Interleave sequence geometry
	localparam int SEQ_LEN = 64;
	localparam int SLOT_W  = 6;
	localparam int TAG_W   = 6;

	// Interleave pattern selection codes
	localparam logic [2:0] PAT_ASC64  = 3'h0;
	localparam logic [2:0] PAT_8_48   = 3'h1;
	localparam logic [2:0] PAT_3RATE  = 3'h2;
	localparam logic [2:0] PAT_REP8   = 3'h3;
	localparam logic [2:0] PAT_16_32  = 3'h4;
	localparam logic [2:0] PAT_4_24   = 3'h5;
	localparam logic [2:0] PAT_12_8   = 3'h6;

	// Reload ordering modes
	localparam logic ORDER_GROUP = 1'b0;
	localparam logic ORDER_FOLD  = 1'b1;

	// Coefficient and reload word layout
	localparam int COEF_W    = 30;
	localparam int RL_W      = 33;
	localparam int LO_W      = 18;
	localparam int SPLIT     = 16;
	localparam int MAX_COEF  = 64;
	localparam int CI_W      = 6;
	localparam int CNT_W     = 7;
	localparam int FOLD_N    = 12;

	// Folded entry operation codes
	localparam logic [1:0] OP_ONE = 2'h0;
	localparam logic [1:0] OP_SUB = 2'h1;
	localparam logic [1:0] OP_ADD = 2'h2;

	typedef struct packed {
		logic [1:0] op;
		logic [3:0] a;
		logic [3:0] b;
	} fold_s;

	// Folded reload table: entry index to source coefficient pair
	function automatic fold_s fold_entry(input logic [3:0] i);
		case (i)
			4'h0:    fold_entry = '{OP_ONE, 4'h7, 4'h0};
			4'h1:    fold_entry = '{OP_ONE, 4'ha, 4'h0};
			4'h2:    fold_entry = '{OP_SUB, 4'h6, 4'h8};
			4'h3:    fold_entry = '{OP_SUB, 4'h9, 4'hb};
			4'h4:    fold_entry = '{OP_ADD, 4'h6, 4'h8};
			4'h5:    fold_entry = '{OP_ADD, 4'h9, 4'hb};
			4'h6:    fold_entry = '{OP_ONE, 4'h1, 4'h0};
			4'h7:    fold_entry = '{OP_ONE, 4'h4, 4'h0};
			4'h8:    fold_entry = '{OP_SUB, 4'h0, 4'h2};
			4'h9:    fold_entry = '{OP_SUB, 4'h3, 4'h5};
			4'ha:    fold_entry = '{OP_ADD, 4'h0, 4'h2};
			4'hb:    fold_entry = '{OP_ADD, 4'h3, 4'h5};
			default: fold_entry = '{OP_ONE, 4'h0, 4'h0};
		endcase
	endfunction

	// Channel tag carried in a given slot of the selected 64-slot sequence
	function automatic logic [TAG_W-1:0] seq_tag(input logic [2:0] pat, input logic [SLOT_W-1:0] s);
		case (pat)
			PAT_ASC64: seq_tag = s;
			PAT_8_48:  seq_tag = (s[1:0] == 2'h0) ? {3'h0, s[4:2]}
				: 6'(6'h08 + 6'(s[5:2]) * 6'h03 + 6'(s[1:0]) - 6'h01);
			PAT_3RATE: seq_tag = !s[0] ? {3'h0, s[3:1]}
				: (!s[1] ? {3'h1, s[4:2]} : 6'(6'h10 + {2'h0, s[5], s[4:2]}));
			PAT_REP8:  seq_tag = (s < 6'h30) ? {3'h0, s[2:0]} : {3'h1, s[2:0]};
			PAT_16_32: seq_tag = !s[0] ? {2'h0, s[4:1]} : 6'(6'h10 + {1'h0, s[5], s[4:1]});
			PAT_4_24:  seq_tag = (s[1:0] == 2'h0) ? {4'h0, s[3:2]}
				: 6'(6'h04 + 6'(s[4:2]) * 6'h03 + 6'(s[1:0]) - 6'h01);
			PAT_12_8:  seq_tag = (s[3:0] < 4'hc) ? {2'h0, s[3:0]}
				: (s[4] ? 6'(6'h04 + {2'h0, s[3:0]}) : {2'h0, s[3:0]});
			default:   seq_tag = s;
		endcase
	endfunction

endpackage

// >>> stream_if.sv
`timescale 1ns/1ps
interface stream_if #(parameter int W = 16);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// >>> stream_fifo.sv
`timescale 1ns/1ps
module stream_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 8
) (
	// Clock, reset and freeze
	input  wire logic mclk,
	input  wire logic arst_n,
	input  wire logic ce,
	// Fill and drain sides
	stream_if.snk     push,
	stream_if.src     pop
);
	localparam int PW = $clog2(DEPTH);

	logic [W-1:0]  mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [PW:0]   cnt_q;
	wire           do_push;
	wire           do_pop;

	// Honest full and empty; a stalled drain side fills the buffer
	assign push.ready = (cnt_q != (PW+1)'(DEPTH));
	assign pop.valid  = (cnt_q != '0);
	assign pop.data   = mem_q[rd_q];
	assign do_push    = ce && push.valid && push.ready;
	assign do_pop     = ce && pop.valid && pop.ready;

	// Storage carries no reset; only pointers define contents
	always_ff @(posedge mclk) begin
		if (do_push) begin
			mem_q[wr_q] <= push.data;
		end
	end

	// Pointer and occupancy bookkeeping
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (do_push) begin
				wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (do_pop) begin
				rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (PW+1)'(do_push) - (PW+1)'(do_pop);
		end
	end

	fifo_bound_a: assert property (@(posedge mclk) disable iff (!arst_n)
		cnt_q <= (PW+1)'(DEPTH)) else $error("fifo occupancy exceeds depth");
	fifo_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
		pop.valid && !pop.ready |=> pop.valid && $stable(pop.data)) else $error("fifo head changed while stalled");
endmodule

// >>> filter_feed_host.sv
`timescale 1ns/1ps

// Summary of operation
// - Each path sample in its own field
// - One channel tag serves all paths
// - Coefficients sent in reordered reload sequence
// - Order computed from implemented coefficient count
// - Symmetric: half padding zeros at both ends
// - Non-symmetric: padding zeros appended at end
// - Folded entries are single coefficients, sums or differences
// - Folded entries built from coefficient bit ranges
// - Groups 12-15, 8-11, 4-7, 0-3 ascending
// - Entries 2 and 4 are c6-c8, c6+c8
// - Low 16 bits zero-extended to 18, upper sign-extended
module filter_feed_host
	import chan_seq_pkg::*;
#(
	parameter int PATHS = 2,
	parameter int SMP_W = 16,
	parameter int DEPTH = 8
) (
	// Clock, reset and freeze
	input  wire logic                             mclk,
	input  wire logic                             arst_n,
	input  wire logic                             ce,
	// User sample input, all paths packed
	input  wire logic                             smp_valid,
	output logic                                  smp_ready,
	input  wire logic [PATHS*SMP_W-1:0]           smp_data,
	input  wire logic [2:0]                       pattern_sel,
	// Sample stream toward the filter
	output logic                                  data_tvalid,
	input  wire logic                             data_tready,
	output logic [PATHS*SMP_W-1:0]                data_tdata,
	output logic [chan_seq_pkg::TAG_W-1:0]        data_tuser,
	output logic                                  data_tlast,
	// Coefficient entry and reload control
	input  wire logic                             coef_wr,
	input  wire logic [chan_seq_pkg::CI_W-1:0]    coef_idx,
	input  wire logic [chan_seq_pkg::COEF_W-1:0]  coef_val,
	input  wire logic                             symmetric,
	input  wire logic [chan_seq_pkg::CNT_W-1:0]   spec_count,
	input  wire logic [chan_seq_pkg::CNT_W-1:0]   act_count,
	input  wire logic                             order_mode,
	input  wire logic [1:0]                       grp_log2,
	input  wire logic                             reload_start,
	output logic                                  reload_busy,
	// Coefficient reload stream toward the filter
	output logic                                  reload_tvalid,
	input  wire logic                             reload_tready,
	output logic [chan_seq_pkg::RL_W-1:0]         reload_tdata,
	output logic                                  reload_tlast
);
	import chan_seq_pkg::*;

	localparam int DW = PATHS * SMP_W;

	typedef enum logic [0:0] {
		RL_IDLE = 1'b0,
		RL_SEND = 1'b1
	} rl_state_e;

	stream_if #(.W(DW)) push_if ();
	stream_if #(.W(DW)) pop_if ();

	logic [SLOT_W-1:0] slot_q;
	logic [TAG_W-1:0]  tag_q;
	logic [COEF_W-1:0] coef_mem [MAX_COEF];
	rl_state_e         rl_state_q;
	logic [CNT_W-1:0]  ridx_q;
	logic [RL_W-1:0]   rl_data_q;
	logic              rl_last_q;

	// Sample buffer: path fields pass through untouched
	assign push_if.valid = smp_valid;
	assign push_if.data  = smp_data;
	assign smp_ready     = push_if.ready;
	assign pop_if.ready  = data_tready;
	assign data_tvalid   = pop_if.valid;
	assign data_tdata    = pop_if.data;

	stream_fifo #(.W(DW), .DEPTH(DEPTH)) u_fifo (
		.mclk   (mclk),
		.arst_n (arst_n),
		.ce     (ce),
		.push   (push_if),
		.pop    (pop_if)
	);

	// Slot stepping; every path rides on one beat, so one tag covers all
	wire               data_fire = ce && data_tvalid && data_tready;
	wire               slot_end  = (slot_q == SLOT_W'(SEQ_LEN-1));
	wire [SLOT_W-1:0]  slot_nx   = slot_end ? '0 : slot_q + 1'b1;
	assign data_tuser = tag_q;
	assign data_tlast = slot_end;

	// Tag is registered ahead; a pattern change only takes effect cleanly from slot 0
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			slot_q <= '0;
			tag_q  <= '0;
		end else if (data_fire) begin
			slot_q <= slot_nx;
			tag_q  <= seq_tag(pattern_sel, slot_nx);
		end
	end

	// Coefficient store, one copy for all paths
	always_ff @(posedge mclk) begin
		if (ce && coef_wr) begin
			coef_mem[coef_idx] <= coef_val;
		end
	end

	// Coefficient at an implemented position, with padding zeros
	wire [CNT_W-1:0] pad_sym = CNT_W'((act_count - spec_count) >> 1);
	function automatic logic [COEF_W-1:0] coef_at(input logic [CNT_W-1:0] k);
		logic [CNT_W-1:0] j;
		j = symmetric ? CNT_W'(k - pad_sym) : k;
		if (symmetric && (k < pad_sym || k >= CNT_W'(pad_sym + spec_count))) begin
			coef_at = '0;
		end else if (!symmetric && k >= spec_count) begin
			coef_at = '0;
		end else begin
			coef_at = coef_mem[j[CI_W-1:0]];
		end
	endfunction

	// Reload word for a given entry index
	function automatic logic [RL_W-1:0] entry_word(input logic [CNT_W-1:0] i);
		fold_s             f;
		logic [CNT_W-1:0]  ng;
		logic [CNT_W-1:0]  k;
		logic [COEF_W-1:0] a;
		logic [COEF_W-1:0] b;
		logic [LO_W-1:0]   lo;
		logic [RL_W-LO_W-1:0] hi;
		logic [COEF_W-1:0] c;
		f  = fold_entry(i[3:0]);
		ng = act_count >> grp_log2;
		k  = CNT_W'(((ng - 1'b1 - (i >> grp_log2)) << grp_log2) | (i & CNT_W'((1 << grp_log2) - 1)));
		c  = coef_at(k);
		a  = coef_at({3'h0, f.a});
		b  = (f.op == OP_ONE) ? '0 : coef_at({3'h0, f.b});
		if (f.op == OP_SUB) begin
			lo = {2'h0, a[SPLIT-1:0]} - {2'h0, b[SPLIT-1:0]};
			hi = {a[COEF_W-1], a[COEF_W-1:SPLIT]} - {b[COEF_W-1], b[COEF_W-1:SPLIT]};
		end else begin
			lo = {2'h0, a[SPLIT-1:0]} + {2'h0, b[SPLIT-1:0]};
			hi = {a[COEF_W-1], a[COEF_W-1:SPLIT]} + {b[COEF_W-1], b[COEF_W-1:SPLIT]};
		end
		if (order_mode == ORDER_FOLD) begin
			entry_word = {hi, lo};
		end else begin
			entry_word = {{(RL_W-COEF_W){c[COEF_W-1]}}, c};
		end
	endfunction

	// Reload sequencing, sized by the implemented count, or by FOLD_N entries in fold mode
	wire [CNT_W-1:0] rl_count = (order_mode == ORDER_FOLD) ? CNT_W'(FOLD_N) : act_count;
	wire             rl_fire  = ce && reload_tvalid && reload_tready;
	wire             rl_go    = ce && reload_start && (rl_state_q == RL_IDLE) && (rl_count != '0);
	wire [CNT_W-1:0] ridx_nx  = rl_go ? '0 : ridx_q + 1'b1;
	assign reload_tvalid = (rl_state_q == RL_SEND);
	assign reload_tdata  = rl_data_q;
	assign reload_tlast  = rl_last_q;
	assign reload_busy   = (rl_state_q == RL_SEND);

	// Word for the next index is registered when the current one is taken
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rl_state_q <= RL_IDLE;
			ridx_q     <= '0;
			rl_data_q  <= '0;
			rl_last_q  <= 1'b0;
		end else if (rl_go || (rl_fire && !rl_last_q)) begin
			rl_state_q <= RL_SEND;
			ridx_q     <= ridx_nx;
			rl_data_q  <= entry_word(ridx_nx);
			rl_last_q  <= (ridx_nx == CNT_W'(rl_count - 1'b1));
		end else if (rl_fire) begin
			rl_state_q <= RL_IDLE;
			rl_last_q  <= 1'b0;
		end
	end

	slot_wrap_a: assert property (@(posedge mclk) disable iff (!arst_n)
		data_fire && slot_end |=> slot_q == '0 && data_tuser == '0) else $error("sequence did not restart");
	asc_tag_a: assert property (@(posedge mclk) disable iff (!arst_n)
		pattern_sel == PAT_ASC64 && $stable(pattern_sel) |-> data_tuser == slot_q) else $error("ascending tag wrong");
	slow_first_a: assert property (@(posedge mclk) disable iff (!arst_n)
		pattern_sel == PAT_8_48 && $past(pattern_sel) == PAT_8_48 && slot_q[1:0] == 2'h0
		|-> data_tuser == {3'h0, slot_q[4:2]}) else $error("slow channel slot wrong");
	three_rate_a: assert property (@(posedge mclk) disable iff (!arst_n)
		pattern_sel == PAT_3RATE && $past(pattern_sel) == PAT_3RATE && !slot_q[0]
		|-> data_tuser == {3'h0, slot_q[3:1]}) else $error("fast channel slot wrong");
	rep_tail_a: assert property (@(posedge mclk) disable iff (!arst_n)
		pattern_sel == PAT_REP8 && $past(pattern_sel) == PAT_REP8 && slot_q >= 6'h30
		|-> data_tuser == {3'h1, slot_q[2:0]}) else $error("tail channel wrong");
	half_split_a: assert property (@(posedge mclk) disable iff (!arst_n)
		pattern_sel == PAT_16_32 && $past(pattern_sel) == PAT_16_32 && slot_q[0]
		|-> data_tuser == 6'(6'h10 + {1'h0, slot_q[5], slot_q[4:1]})) else $error("odd slot channel wrong");
	quad_lead_a: assert property (@(posedge mclk) disable iff (!arst_n)
		pattern_sel == PAT_4_24 && $past(pattern_sel) == PAT_4_24 && slot_q[1:0] == 2'h0
		|-> data_tuser == {4'h0, slot_q[3:2]}) else $error("lead channel wrong");
	quarter_body_a: assert property (@(posedge mclk) disable iff (!arst_n)
		pattern_sel == PAT_12_8 && $past(pattern_sel) == PAT_12_8 && slot_q[3:0] < 4'hc
		|-> data_tuser == {2'h0, slot_q[3:0]}) else $error("quarter body channel wrong");
	reload_end_a: assert property (@(posedge mclk) disable iff (!arst_n)
		rl_fire && reload_tlast |=> !reload_tvalid && !reload_busy) else $error("reload ran past last entry");
	reload_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
		reload_tvalid && !reload_tready |=> reload_tvalid && $stable(reload_tdata) && $stable(reload_tlast))
		else $error("reload word changed while stalled");
endmodule

// >>> filter_model.sv
`timescale 1ns/1ps
// Stands in for the filter: takes sample and reload beats and stalls at random
module filter_model #(
	parameter int DW = 32
) (
	// Clock and control
	input  wire logic          mclk,
	input  wire logic          arst_n,
	input  wire logic          stall,
	// Sample stream
	input  wire logic          data_tvalid,
	output logic               data_tready,
	input  wire logic [DW-1:0] data_tdata,
	input  wire logic [5:0]    data_tuser,
	input  wire logic          data_tlast,
	// Reload stream
	input  wire logic          reload_tvalid,
	output logic               reload_tready,
	input  wire logic [32:0]   reload_tdata,
	input  wire logic          reload_tlast
);
	logic [DW+6:0] dq[$];
	logic [33:0]   rq[$];

	// Ready is low until the first edge; capture is gated by arst_n, so nothing is taken during reset
	initial begin
		data_tready = 1'b0;
		reload_tready = 1'b0;
	end

	// One tag field covers every path; one coefficient port serves them all
	always @(posedge mclk) begin
		if (arst_n && data_tvalid && data_tready)
			dq.push_back({data_tlast, data_tuser, data_tdata});
		if (arst_n && reload_tvalid && reload_tready)
			rq.push_back({reload_tlast, reload_tdata});
		#1;
		data_tready = !stall && ($urandom_range(3) != 0);
		reload_tready = $urandom_range(2) != 0;
	end
endmodule

// >>> tb.sv
`timescale 1ns/1ps
module tb;
	import chan_seq_pkg::*;
	localparam int DW = 32;
	logic              mclk, arst_n, smp_valid, smp_ready, data_tvalid, data_tready, data_tlast, stall;
	logic              coef_wr, symmetric, order_mode, reload_start, reload_busy, ce;
	logic              reload_tvalid, reload_tready, reload_tlast;
	logic [DW-1:0]     smp_data, data_tdata;
	logic [2:0]        pattern_sel;
	logic [TAG_W-1:0]  data_tuser;
	logic [CI_W-1:0]   coef_idx;
	logic [COEF_W-1:0] coef_val;
	logic [CNT_W-1:0]  spec_count, act_count;
	logic [1:0]        grp_log2;
	logic [RL_W-1:0]   reload_tdata;
	logic [COEF_W-1:0] cf[64];
	logic [DW+6:0]     eq[$];
	int                fail_count, compares, p;
	int                fa[12] = '{7, 10, 6, 9, 6, 9, 1, 4, 0, 3, 0, 3};
	int                fb[12] = '{0, 0, 8, 11, 8, 11, 0, 0, 2, 5, 2, 5};
	int                fo[12] = '{0, 0, 1, 1, 2, 2, 0, 0, 1, 1, 2, 2};

	filter_feed_host #(.PATHS(2), .SMP_W(16), .DEPTH(8)) dut_u (.mclk(mclk), .arst_n(arst_n), .ce(ce),
		.smp_valid(smp_valid), .smp_ready(smp_ready), .smp_data(smp_data), .pattern_sel(pattern_sel),
		.data_tvalid(data_tvalid), .data_tready(data_tready), .data_tdata(data_tdata),
		.data_tuser(data_tuser), .data_tlast(data_tlast), .coef_wr(coef_wr), .coef_idx(coef_idx),
		.coef_val(coef_val), .symmetric(symmetric), .spec_count(spec_count), .act_count(act_count),
		.order_mode(order_mode), .grp_log2(grp_log2), .reload_start(reload_start),
		.reload_busy(reload_busy), .reload_tvalid(reload_tvalid), .reload_tready(reload_tready),
		.reload_tdata(reload_tdata), .reload_tlast(reload_tlast));

	filter_model #(.DW(DW)) partner_u (.mclk(mclk), .arst_n(arst_n), .stall(stall),
		.data_tvalid(data_tvalid), .data_tready(data_tready), .data_tdata(data_tdata),
		.data_tuser(data_tuser), .data_tlast(data_tlast), .reload_tvalid(reload_tvalid),
		.reload_tready(reload_tready), .reload_tdata(reload_tdata), .reload_tlast(reload_tlast));

	// 200 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic bad(input string m);
		fail_count++;
		$display("BAD t=%0t %s", $time, m);
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string m);
		compares++;
		if (got !== exp) bad(m);
	endtask

	task automatic chk_beat(input logic [DW+6:0] got, input logic [DW+6:0] exp);
		compares++;
		if (got !== exp) bad($sformatf("beat %h expected %h", got, exp));
	endtask

	task automatic chk_rl(input logic [33:0] got, input logic [33:0] exp);
		compares++;
		if (got !== exp) bad($sformatf("reload %h expected %h", got, exp));
	endtask

	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic tick();
		@(posedge mclk);
		#1;
	endtask

	// Bounded wait on a condition sampled one cycle at a time
	task automatic wait_for(input int lim, input bit dq_wait, input int n);
		int w;
		w = 0;
		while ((dq_wait ? partner_u.dq.size() < n : reload_busy === 1'b1) && w < lim) begin
			tick();
			w++;
		end
		if (w >= lim) begin
			bad("wait timeout");
			final_report();
		end
	endtask

	task automatic do_reset(input int n);
		arst_n = 1'b0;
		repeat (n) tick();
		chk_bit(smp_ready, 1'b1, "reset ready");
		chk_bit(data_tvalid, 1'b0, "reset valid");
		chk_bit(reload_busy, 1'b0, "reset busy");
		arst_n = 1'b1;
		partner_u.dq.delete();
		partner_u.rq.delete();
	endtask

	// Reference channel order of each selectable sequence
	function automatic int exp_tag(int pt, int s);
		int t;
		t = s % 32;
		case (pt)
			1: return (s % 4 == 0) ? (s / 4) % 8 : 8 + (s / 4) * 3 + s % 4 - 1;
			2: return (s % 2 == 0) ? (s / 2) % 8 : (s % 4 == 1) ? 8 + (s / 4) % 8 : 16 + s / 4;
			3: return (s < 48) ? s % 8 : 8 + s % 8;
			4: return (s % 2 == 0) ? (s / 2) % 16 : 16 + s / 2;
			5: return (t % 4 == 0) ? (t / 4) % 4 : 4 + (t / 4) * 3 + t % 4 - 1;
			6: return (s % 16 < 12 || s % 32 < 16) ? s % 16 : s % 16 + 4;
			default: return s;
		endcase
	endfunction

	// Fill the buffer against a stalled filter, then stream past the wrap
	task automatic run_pat(input int pt);
		int n;
		logic ok;
		logic [DW-1:0] d;
		stall = 1'b1;
		pattern_sel = 3'(pt);
		do_reset(2);
		for (n = 0; n < 66; n++) begin
			d = $urandom();
			smp_data = d;
			smp_valid = 1'b1;
			repeat (200) begin
				@(negedge mclk);
				ok = smp_ready;
				tick();
				if (ok) break;
			end
			if (!ok) begin
				bad("push refused");
				final_report();
			end
			eq.push_back({1'(n % 64 == 63), 6'(exp_tag(pt, n % 64)), d});
			if (n == 7 || $urandom_range(4) == 0) begin
				smp_valid = 1'b0;
				@(negedge mclk);
				if (n == 7) chk_bit(smp_ready, 1'b0, "full");
				stall = (n < 7); // Keep the filter held off until the buffer has been seen full
				tick();
			end
		end
		smp_valid = 1'b0;
		wait_for(2000, 1'b1, 66);
		tick();
		chk_bit(data_tvalid, 1'b0, "drained");
		foreach (eq[i]) chk_beat(partner_u.dq[i], eq[i]);
		eq.delete();
		$display("test pattern %0d done", pt);
	endtask

	// Load coefficients, reload them, and compare each word with the padded reordered set
	task automatic run_rl(input bit sym, input int spec, input int act, input bit mode, input int gl);
		int i, e, n;
		logic [COEF_W-1:0] pd[64];
		logic [COEF_W-1:0] a, b;
		logic [17:0] lo;
		logic [14:0] hi;
		logic [33:0] ex[$];
		for (i = 0; i < spec; i++) begin
			cf[i] = 30'($urandom());
			coef_wr = 1'b1;
			coef_idx = 6'(i);
			coef_val = cf[i];
			tick();
		end
		// A write and a start while frozen must both be ignored
		ce = 1'b0;
		coef_idx = '0;
		coef_val = ~cf[0];
		reload_start = 1'b1;
		tick();
		ce = 1'b1;
		coef_wr = 1'b0;
		reload_start = 1'b0;
		chk_bit(reload_busy, 1'b0, "frozen start");
		for (i = 0; i < 64; i++) pd[i] = '0;
		for (i = 0; i < spec; i++) pd[i + (sym ? (act - spec) / 2 : 0)] = cf[i];
		n = mode ? FOLD_N : act;
		for (i = 0; i < n; i++) begin
			if (mode) begin
				a = pd[fa[i]];
				b = (fo[i] == 0) ? '0 : pd[fb[i]];
				lo = (fo[i] == 1) ? {2'h0, a[15:0]} - {2'h0, b[15:0]} : {2'h0, a[15:0]} + {2'h0, b[15:0]};
				hi = (fo[i] == 1) ? {a[29], a[29:16]} - {b[29], b[29:16]} : {a[29], a[29:16]} + {b[29], b[29:16]};
				ex.push_back({1'(i == n - 1), hi, lo});
			end else begin
				e = ((act >> gl) - 1 - (i >> gl)) * (1 << gl) + i % (1 << gl);
				ex.push_back({1'(i == n - 1), {3{pd[e][29]}}, pd[e]});
			end
		end
		symmetric = sym;
		spec_count = 7'(spec);
		act_count = 7'(act);
		order_mode = mode;
		grp_log2 = 2'(gl);
		reload_start = 1'b1;
		tick();
		reload_start = 1'b0;
		tick();
		chk_bit(reload_busy, 1'(n > 0), "busy");
		reload_start = 1'b1;
		tick();
		reload_start = 1'b0;
		wait_for(500, 1'b0, 0);
		repeat (3) tick();
		chk_bit(1'(partner_u.rq.size() == n), 1'b1, "beat count");
		foreach (ex[i]) chk_rl(partner_u.rq[i], ex[i]);
		partner_u.rq.delete();
		$display("reload test act %0d mode %0d done", act, mode);
	endtask

	initial begin
		fail_count = 0;
		compares = 0;
		ce = 1'b1;
		arst_n = 1'b0;
		stall = 1'b1;
		smp_valid = 1'b0;
		smp_data = '0;
		pattern_sel = 3'h0;
		coef_wr = 1'b0;
		coef_idx = '0;
		coef_val = '0;
		symmetric = 1'b0;
		spec_count = '0;
		act_count = '0;
		order_mode = 1'b0;
		grp_log2 = 2'h2;
		reload_start = 1'b0;
		void'($urandom(32'ha52483b3));
		do_reset(8);
		for (p = 0; p < 8; p++) run_pat(p);
		run_rl(1'b0, 16, 16, 1'b0, 2);
		run_rl(1'b0, 14, 16, 1'b0, 2);
		run_rl(1'b1, 14, 16, 1'b0, 1);
		run_rl(1'b1, 12, 12, 1'b1, 0);
		run_rl(1'b0, 0, 0, 1'b0, 2);
		final_report();
	end
endmodule
